// >>> pkg/rdw_pkg.sv
// Constants and mode types for the dual-port RAM with collision handling
package collision_pkg;

  typedef enum logic [3:0] {
    same_address_collision_new = 4'h1,
    same_address_collision_old = 4'h2,
    same_address_collision_dc = 4'h4,
    same_address_collision_none = 4'h8
  } collision_mode_type;

  typedef enum logic [1:0] {
    new_data_keep_masked_old = 2'h1,
    new_data_masked_unknown = 2'h2
  } mask_variant_type;

  typedef enum logic [2:0] {
    cfg_single_port = 3'h1,
    cfg_simple_dual = 3'h2,
    cfg_true_dual = 3'h4
  } port_config_type;

  typedef enum logic [2:0] {
    clk_single = 3'h1,
    clk_in_out = 3'h2,
    clk_independent = 3'h4
  } clock_mode_type;

  typedef enum logic [2:0] {
    blk_generic = 3'h1,
    blk_distributed = 3'h2,
    blk_large_block = 3'h4
  } block_kind_type;

  localparam int DEF_DATA_W = 16;
  localparam int DEF_BYTE_W = 8;
  localparam int DEF_ADDR_W = 4;
  localparam logic DQ_RESET_BIT = 1'b0;
  // Fill value for an output the user must not rely on
  localparam logic UNKNOWN_FILL_BIT = 1'b0;

endpackage : collision_pkg

// >>> core/rdw_lane_mux.sv
// One byte lane of the collision output selector
`timescale 1ns/1ps
module lane_select #(
  parameter int LANE_W = 8
) (
  // Lane sources
  input wire logic [LANE_W-1:0] stored_i,
  input wire logic [LANE_W-1:0] wdata_i,
  input wire logic lane_en_i,
  // Selection
  input wire logic collide_i,
  input wire logic new_mode_i,
  input wire logic unknown_mode_i,
  input wire logic mask_unknown_i,
  // Lane result
  output logic [LANE_W-1:0] lane_o
);
  import collision_pkg::*;

  wire logic [LANE_W-1:0] fill_w = {LANE_W{UNKNOWN_FILL_BIT}};
  wire logic [LANE_W-1:0] masked_w = mask_unknown_i ? fill_w : stored_i;
  wire logic [LANE_W-1:0] newsel_w = lane_en_i ? wdata_i : masked_w;
  assign lane_o = !collide_i ? stored_i : unknown_mode_i ? fill_w : new_mode_i ? newsel_w : stored_i;

endmodule : lane_select

// >>> core/rdw_read_port.sv
// Read side of one port: collision selection per lane and output hold
`timescale 1ns/1ps
module read_port_hold #(
  parameter int DATA_W = 16,
  parameter int BYTE_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Read request
  input wire logic rden_i,
  input wire logic [DATA_W-1:0] stored_i,
  // Colliding write
  input wire logic collide_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [DATA_W/BYTE_W-1:0] byteen_i,
  input wire logic new_mode_i,
  input wire logic unknown_mode_i,
  input wire logic mask_unknown_i,
  // Output
  output logic [DATA_W-1:0] q_o
);
  import collision_pkg::*;
  localparam int LANES = DATA_W / BYTE_W;

  logic [DATA_W-1:0] q_reg;
  wire logic [DATA_W-1:0] q_next;

  generate
    for (genvar g = 0; g < LANES; g++) begin : g_lane
      lane_select #(.LANE_W(BYTE_W)) u_lane (
        .stored_i(stored_i[g*BYTE_W +: BYTE_W]),
        .wdata_i(wdata_i[g*BYTE_W +: BYTE_W]),
        .lane_en_i(byteen_i[g]),
        .collide_i(collide_i),
        .new_mode_i(new_mode_i),
        .unknown_mode_i(unknown_mode_i),
        .mask_unknown_i(mask_unknown_i),
        .lane_o(q_next[g*BYTE_W +: BYTE_W])
      );
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q_reg <= {DATA_W{DQ_RESET_BIT}};
    end else if (rden_i) begin
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;

endmodule : read_port_hold

// >>> core/ram_read_during_write.sv
// Dual-port synchronous RAM with configurable read-during-write behaviour
`timescale 1ns/1ps
module ram_read_during_write
  import collision_pkg::*;
#(
  parameter int DATA_W = DEF_DATA_W,
  parameter int BYTE_W = DEF_BYTE_W,
  parameter int ADDR_W = DEF_ADDR_W,
  parameter port_config_type PORT_CFG = cfg_true_dual,
  parameter clock_mode_type CLK_MODE = clk_single,
  parameter block_kind_type BLOCK_KIND = blk_generic,
  parameter bit HAS_RDEN = 1'b1,
  parameter bit ECC_EN = 1'b0,
  parameter bit OPTION_SELECTABLE = 1'b1,
  parameter collision_mode_type SAME_MODE = same_address_collision_new,
  parameter collision_mode_type MIXED_MODE = same_address_collision_old,
  parameter mask_variant_type MASK_VARIANT = new_data_keep_masked_old
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Port A
  input wire logic [ADDR_W-1:0] a_addr_i,
  input wire logic [DATA_W-1:0] a_wdata_i,
  input wire logic a_wren_i,
  input wire logic [DATA_W/BYTE_W-1:0] a_byteen_i,
  input wire logic a_rden_i,
  output logic [DATA_W-1:0] a_q_o,
  // Port B
  input wire logic [ADDR_W-1:0] b_addr_i,
  input wire logic [DATA_W-1:0] b_wdata_i,
  input wire logic b_wren_i,
  input wire logic [DATA_W/BYTE_W-1:0] b_byteen_i,
  input wire logic b_rden_i,
  output logic [DATA_W-1:0] b_q_o,
  // Status
  output logic mixed_collision_o,
  output logic same_collision_o
);

  localparam int LANES = DATA_W / BYTE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // Configuration legality checks
  localparam bit SAME_OK = (PORT_CFG != cfg_simple_dual) &&
    ((PORT_CFG == cfg_true_dual) || (CLK_MODE != clk_independent));
  localparam bit MIXED_OK = (PORT_CFG != cfg_single_port) && (CLK_MODE != clk_independent);
  localparam bit OLD_FORBIDDEN_SAME = ECC_EN ||
    ((BLOCK_KIND == blk_large_block) && (PORT_CFG != cfg_simple_dual));

  initial begin
    if (DATA_W < 1 || BYTE_W < 1 || (DATA_W % BYTE_W) != 0) begin
      $error("Data width must be a whole number of byte lanes");
    end
    if (ADDR_W < 1 || ADDR_W > 16) begin
      $error("Address width out of range");
    end
    if (PORT_CFG == cfg_single_port && CLK_MODE == clk_independent) begin
      $error("Single-port RAM needs single or input/output clocking");
    end
    if (PORT_CFG == cfg_simple_dual && CLK_MODE == clk_independent) begin
      $error("Simple dual-port RAM needs single or input/output clocking");
    end
    if (OLD_FORBIDDEN_SAME && SAME_MODE == same_address_collision_old) begin
      $error("Old-data same-port mode not available here");
    end
    if (ECC_EN && MIXED_MODE == same_address_collision_old) begin
      $error("Old-data mode not available with error correction");
    end
    if (BLOCK_KIND == blk_distributed && PORT_CFG == cfg_simple_dual &&
        MIXED_MODE == same_address_collision_new &&
        (CLK_MODE != clk_single || MASK_VARIANT != new_data_masked_unknown)) begin
      $error("Distributed new-data needs single clock and unknown-lane variant");
    end
    if (MIXED_MODE == same_address_collision_new && BLOCK_KIND != blk_distributed) begin
      $error("Mixed-port new-data only on distributed memory");
    end
  end

  // Effective modes after the configuration limits
  localparam collision_mode_type SAME_EFF = !OPTION_SELECTABLE ? same_address_collision_new : SAME_MODE;
  localparam collision_mode_type MIXED_EFF =
    (MIXED_MODE == same_address_collision_old && (CLK_MODE != clk_single || ECC_EN)) ?
    same_address_collision_dc : MIXED_MODE;
  localparam bit MASK_UNK = (MASK_VARIANT == new_data_masked_unknown);

  // Storage
  logic [DATA_W-1:0] mem_reg [DEPTH];

  // Port-use decode by configuration
  wire logic a_wr_w = a_wren_i && (PORT_CFG != cfg_simple_dual || 1'b1);
  wire logic b_wr_w = b_wren_i && (PORT_CFG == cfg_true_dual);
  wire logic a_rd_w = (HAS_RDEN ? a_rden_i : 1'b1) && (PORT_CFG != cfg_simple_dual);
  wire logic b_rd_w = (HAS_RDEN ? b_rden_i : 1'b1) && (PORT_CFG != cfg_single_port);

  // Collision detection: same word, same cycle
  wire logic same_a_w = SAME_OK && a_wr_w && a_rd_w;
  wire logic same_b_w = SAME_OK && b_wr_w && b_rd_w;
  wire logic mix_ab_w = MIXED_OK && a_wr_w && b_rd_w && (a_addr_i == b_addr_i);
  wire logic mix_ba_w = MIXED_OK && b_wr_w && a_rd_w && (a_addr_i == b_addr_i);

  // Mode bits for each reading port; same-port takes precedence
  wire collision_mode_type a_mode_w = same_a_w ? SAME_EFF : MIXED_EFF;
  wire collision_mode_type b_mode_w = same_b_w ? SAME_EFF : MIXED_EFF;
  wire logic a_collide_w = same_a_w || mix_ba_w;
  wire logic b_collide_w = same_b_w || mix_ab_w;
  wire logic [DATA_W-1:0] a_src_w = same_a_w ? a_wdata_i : b_wdata_i;
  wire logic [DATA_W-1:0] b_src_w = same_b_w ? b_wdata_i : a_wdata_i;
  wire logic [LANES-1:0] a_be_w = same_a_w ? a_byteen_i : b_byteen_i;
  wire logic [LANES-1:0] b_be_w = same_b_w ? b_byteen_i : a_byteen_i;

  wire logic a_new_w = (a_mode_w == same_address_collision_new);
  wire logic b_new_w = (b_mode_w == same_address_collision_new);
  wire logic a_unk_w = (a_mode_w == same_address_collision_dc);
  wire logic b_unk_w = (b_mode_w == same_address_collision_dc);

  // Read of stored word before this edge's write; old data falls out of this
  wire logic [DATA_W-1:0] a_stored_w = mem_reg[a_addr_i];
  wire logic [DATA_W-1:0] b_stored_w = mem_reg[b_addr_i];

  logic [DATA_W-1:0] a_q_w;
  logic [DATA_W-1:0] b_q_w;

  read_port_hold #(.DATA_W(DATA_W), .BYTE_W(BYTE_W)) u_port_a (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .rden_i(a_rd_w),
    .stored_i(a_stored_w),
    .collide_i(a_collide_w),
    .wdata_i(a_src_w),
    .byteen_i(a_be_w),
    .new_mode_i(a_new_w),
    .unknown_mode_i(a_unk_w),
    .mask_unknown_i(MASK_UNK),
    .q_o(a_q_w)
  );

  read_port_hold #(.DATA_W(DATA_W), .BYTE_W(BYTE_W)) u_port_b (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .rden_i(b_rd_w),
    .stored_i(b_stored_w),
    .collide_i(b_collide_w),
    .wdata_i(b_src_w),
    .byteen_i(b_be_w),
    .new_mode_i(b_new_w),
    .unknown_mode_i(b_unk_w),
    .mask_unknown_i(MASK_UNK),
    .q_o(b_q_w)
  );

  assign a_q_o = a_q_w;
  assign b_q_o = b_q_w;

  // Byte-masked writes; port B wins on each lane that both ports write in one word
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < LANES; i++) begin
      if (a_wr_w && a_byteen_i[i] && !(b_wr_w && b_byteen_i[i] && a_addr_i == b_addr_i)) begin
        mem_reg[a_addr_i][i*BYTE_W +: BYTE_W] <= a_wdata_i[i*BYTE_W +: BYTE_W];
      end
      if (b_wr_w && b_byteen_i[i]) begin
        mem_reg[b_addr_i][i*BYTE_W +: BYTE_W] <= b_wdata_i[i*BYTE_W +: BYTE_W];
      end
    end
  end

  // Collision flags for observation
  logic same_reg;
  logic mixed_reg;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      same_reg <= 1'b0;
      mixed_reg <= 1'b0;
    end else begin
      same_reg <= same_a_w || same_b_w;
      mixed_reg <= mix_ab_w || mix_ba_w;
    end
  end
  assign same_collision_o = same_reg;
  assign mixed_collision_o = mixed_reg;

endmodule : ram_read_during_write

// >>> tb/ram_rdw_chk.sv
// Port-level assertions for the collision RAM
`timescale 1ns/1ps
module ram_collision_chk #(
  parameter int DATA_W = 16,
  parameter int BYTE_W = 8,
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Port A
  input wire logic [ADDR_W-1:0] a_addr_i,
  input wire logic [DATA_W-1:0] a_wdata_i,
  input wire logic a_wren_i,
  input wire logic [DATA_W/BYTE_W-1:0] a_byteen_i,
  input wire logic a_rden_i,
  input wire logic [DATA_W-1:0] a_q_o,
  // Port B
  input wire logic [ADDR_W-1:0] b_addr_i,
  input wire logic [DATA_W-1:0] b_wdata_i,
  input wire logic b_wren_i,
  input wire logic [DATA_W/BYTE_W-1:0] b_byteen_i,
  input wire logic b_rden_i,
  input wire logic [DATA_W-1:0] b_q_o,
  // Status
  input wire logic mixed_collision_o,
  input wire logic same_collision_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_a_same;
    a_wren_i && a_rden_i;
  endsequence
  sequence s_b_same;
    b_wren_i && b_rden_i;
  endsequence
  // B writes without reading, A reads the same word
  sequence s_b_mixed;
    b_wren_i && !b_rden_i && !a_wren_i && a_rden_i && (a_addr_i == b_addr_i);
  endsequence
  sequence s_quiet_read;
    a_rden_i && !a_wren_i && !b_wren_i;
  endsequence
  chk_hold_port_a: assert property (!a_rden_i |=> $stable(a_q_o))
    else $error("port A output moved without read enable");
  chk_hold_port_b: assert property (!b_rden_i |=> $stable(b_q_o))
    else $error("port B output moved without read enable");
  chk_new_full_a: assert property (s_a_same ##0 (a_byteen_i == '1) |=> a_q_o == $past(a_wdata_i))
    else $error("port A new data not shown");
  chk_new_full_b: assert property (s_b_same ##0 (b_byteen_i == '1) |=> b_q_o == $past(b_wdata_i))
    else $error("port B new data not shown");
  chk_same_flag: assert property (s_a_same or s_b_same |=> same_collision_o)
    else $error("same-port collision not flagged");
  chk_mixed_flag: assert property (s_b_mixed |=> mixed_collision_o)
    else $error("mixed-port collision not flagged");
  chk_quiet_flags: assert property (!a_wren_i && !b_wren_i |=> !same_collision_o && !mixed_collision_o)
    else $error("collision flagged with no write");
  chk_read_stable: assert property (s_quiet_read ##1 (s_quiet_read and $stable(a_addr_i)) |=> $stable(a_q_o))
    else $error("repeated read of unchanged word differs");
endmodule : ram_collision_chk

// >>> tb/port_user.sv
// User logic model driving one memory port
`timescale 1ns/1ps
module port_user #(
  parameter int DATA_W = 16,
  parameter int BE_W = 2,
  parameter int ADDR_W = 4
) (
  // Port request
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o,
  output logic wren_o,
  output logic [BE_W-1:0] byteen_o,
  output logic rden_o
);
  initial begin
    put('0, '0, 1'h0, '0, 1'h0);
  end
  // Called just after an edge; values stand for the whole cycle
  task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic w,
                     input logic [BE_W-1:0] be, input logic r);
    addr_o = a;
    wdata_o = d;
    wren_o = w;
    byteen_o = be;
    rden_o = r;
  endtask : put
endmodule : port_user

// >>> tb/tb_top.sv
// Self-checking bench for the collision RAM
`timescale 1ns/1ps
module tb_top;
  import collision_pkg::*;
  localparam int DW = 16;
  localparam int BW = 8;
  localparam int NB = 2;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] a_addr, b_addr;
  logic [DW-1:0] a_wdata, b_wdata, a_q, b_q, exp_a = '0, exp_b = '0;
  logic [NB-1:0] a_be, b_be;
  logic a_wren, b_wren, a_rden, b_rden, mixed_c, same_c;
  logic exp_same = 1'b0;
  logic exp_mix = 1'b0;
  logic [DW-1:0] mem [16];
  logic [31:0] r1, r2;
  int failures = 0;
  int checked = 0;
  int seed = 4;
  always #10 core_clk_i = ~core_clk_i;
  port_user u_user_a (.addr_o(a_addr), .wdata_o(a_wdata), .wren_o(a_wren), .byteen_o(a_be), .rden_o(a_rden));
  port_user u_user_b (.addr_o(b_addr), .wdata_o(b_wdata), .wren_o(b_wren), .byteen_o(b_be), .rden_o(b_rden));
  ram_read_during_write u_ram_read_during_write (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .a_addr_i(a_addr), .a_wdata_i(a_wdata), .a_wren_i(a_wren), .a_byteen_i(a_be), .a_rden_i(a_rden), .a_q_o(a_q),
    .b_addr_i(b_addr), .b_wdata_i(b_wdata), .b_wren_i(b_wren), .b_byteen_i(b_be), .b_rden_i(b_rden), .b_q_o(b_q),
    .mixed_collision_o(mixed_c), .same_collision_o(same_c));
  // Enabled lanes take the write, masked lanes keep the old word
  function automatic logic [DW-1:0] merge(logic [DW-1:0] d, logic [NB-1:0] be, logic [DW-1:0] old);
    logic [DW-1:0] m;
    m = old;
    for (int i = 0; i < NB; i++) if (be[i]) m[i*BW +: BW] = d[i*BW +: BW];
    return m;
  endfunction : merge
  task automatic check(string what, logic [DW-1:0] e, logic [DW-1:0] s);
    checked++;
    if (e !== s) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : check
  // One cycle: judge the last edge, then apply new requests
  task automatic step(logic [3:0] aa, logic [DW-1:0] ad, logic aw, logic [NB-1:0] abe, logic ar,
                      logic [3:0] ba, logic [DW-1:0] bd, logic bw, logic [NB-1:0] bbe, logic br);
    @(posedge core_clk_i);
    #1;
    check("a_q_o", exp_a, a_q);
    check("b_q_o", exp_b, b_q);
    check("same_collision_o", {15'h0, exp_same}, {15'h0, same_c});
    check("mixed_collision_o", {15'h0, exp_mix}, {15'h0, mixed_c});
    // Two writers on one word is left out; lane winner is a design choice
    if (aw && bw && aa == ba) bw = 1'b0;
    u_user_a.put(aa, ad, aw, abe, ar);
    u_user_b.put(ba, bd, bw, bbe, br);
    if (ar) exp_a = aw ? merge(ad, abe, mem[aa]) : mem[aa];
    if (br) exp_b = bw ? merge(bd, bbe, mem[ba]) : mem[ba];
    exp_same = (aw && ar) || (bw && br);
    exp_mix = (aa == ba) && ((aw && br) || (bw && ar));
    if (aw) mem[aa] = merge(ad, abe, mem[aa]);
    if (bw) mem[ba] = merge(bd, bbe, mem[ba]);
  endtask : step
  task automatic rand_run(int n);
    for (int k = 0; k < n; k++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      // Two address bits only, so collisions are frequent
      step({2'h0, r1[1:0]}, r2[15:0], r1[2], r1[4:3], r1[5],
           {2'h0, r1[7:6]}, r2[31:16], r1[8], r1[10:9], r1[11]);
    end
  endtask : rand_run
  task automatic tally_and_finish;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (16) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    for (int i = 0; i < 16; i++) begin
      r2 = $random(seed);
      step(i[3:0], r2[15:0], 1'h1, 2'h3, 1'h0, 4'h0, 16'h0, 1'h0, 2'h0, 1'h0);
    end
    $display("test fill done");
    step(4'h3, 16'hA5A5, 1'h1, 2'h3, 1'h1, 4'h3, 16'h0, 1'h0, 2'h0, 1'h1);
    step(4'h3, 16'h1234, 1'h1, 2'h1, 1'h1, 4'h5, 16'hBEEF, 1'h1, 2'h3, 1'h1);
    step(4'h3, 16'h0, 1'h0, 2'h0, 1'h1, 4'h3, 16'h0F0F, 1'h1, 2'h2, 1'h0);
    step(4'h3, 16'hFFFF, 1'h1, 2'h3, 1'h0, 4'h3, 16'h0, 1'h0, 2'h0, 1'h1);
    $display("test corners done");
    rand_run(300);
    $display("test random first half done");
    @(posedge core_clk_i);
    #1;
    u_user_a.put(4'h0, 16'h0, 1'h0, 2'h0, 1'h0);
    u_user_b.put(4'h0, 16'h0, 1'h0, 2'h0, 1'h0);
    rst_n_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    exp_a = '0;
    exp_b = '0;
    exp_same = 1'b0;
    exp_mix = 1'b0;
    rand_run(300);
    step(4'h0, 16'h0, 1'h0, 2'h0, 1'h0, 4'h0, 16'h0, 1'h0, 2'h0, 1'h0);
    $display("test random after reset done");
    tally_and_finish();
  end
endmodule : tb_top
bind ram_read_during_write ram_collision_chk #(.DATA_W(DATA_W), .BYTE_W(BYTE_W), .ADDR_W(ADDR_W)) u_ram_collision_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .a_addr_i(a_addr_i), .a_wdata_i(a_wdata_i), .a_wren_i(a_wren_i),
  .a_byteen_i(a_byteen_i), .a_rden_i(a_rden_i), .a_q_o(a_q_o), .b_addr_i(b_addr_i), .b_wdata_i(b_wdata_i),
  .b_wren_i(b_wren_i), .b_byteen_i(b_byteen_i), .b_rden_i(b_rden_i), .b_q_o(b_q_o),
  .mixed_collision_o(mixed_collision_o), .same_collision_o(same_collision_o));
